// file: core/io_chk_pkg.sv
// Shared constants, types and helpers of the port access checker
package io_chk_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_TSS_BASE = 8'h08;
  localparam logic [7:0] OFS_TSS_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_MAP_BASE = 8'h10;
  localparam logic [7:0] OFS_PORT_INDEX = 8'h14;
  localparam logic [7:0] OFS_ACC = 8'h18;
  localparam logic [7:0] OFS_SRC_PTR = 8'h1C;
  localparam logic [7:0] OFS_DST_PTR = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // ==========================================================
  // Field positions
  localparam int CTRL_CPL_LSB = 0;
  localparam int CTRL_PROT_BIT = 2;
  localparam int CTRL_VM86_BIT = 3;
  localparam int CTRL_DIR_BIT = 4;
  localparam int FLAGS_IF_BIT = 9;
  localparam int FLAGS_IO_PRIVILEGE_FIELD_LSB = 12;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;

  // ==========================================================
  // Values after reset and fixed codes
  localparam logic [1:0] PRIV_RST = 2'h0;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Stands in for map bytes past the segment limit
  localparam logic [7:0] MAP_BYTE_DENY = 8'hFF;
  // 64K byte ports, 0 to FFFFH
  localparam int PORT_W = 16;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    OP_PORT_READ, OP_PORT_WRITE, OP_STR_READ, OP_STR_WRITE,
    OP_IF_CLEAR, OP_IF_SET, OP_FLAG_POP, OP_INT_RETURN
  } io_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} io_size_t;

  typedef struct packed {
    io_op_t op;
    io_size_t size;
    logic use_imm;
    logic [PORT_W-1:0] imm_port;
    logic looping_prefix;
    logic [1:0] pop_io_privilege_field;
    logic pop_if;
  } io_req_t;

  typedef struct packed {
    logic rd;
    logic [31:0] addr;
  } map_req_t;

  typedef struct packed {
    logic stb;
    logic we;
    logic [PORT_W-1:0] addr;
    io_size_t size;
    logic [31:0] wdata;
  } io_bus_t;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] size_mask(input io_size_t sz);
    unique case (sz)
      SZ_DWORD: size_mask = 4'hF;
      SZ_WORD: size_mask = 4'h3;
      default: size_mask = 4'h1;
    endcase
  endfunction : size_mask

  function automatic logic [31:0] size_bytes(input io_size_t sz);
    unique case (sz)
      SZ_DWORD: size_bytes = 32'h0000_0004;
      SZ_WORD: size_bytes = 32'h0000_0002;
      default: size_bytes = 32'h0000_0001;
    endcase
  endfunction : size_bytes

endpackage : io_chk_pkg

// file: core/port_map_window.sv
// Tests the permission bits of every byte port an access covers
`timescale 1ns/1ps
module port_map_window (
  // Two consecutive map bytes
  input wire logic [7:0] lo_i,
  input wire logic [7:0] hi_i,
  // Access shape
  input wire logic [2:0] bit_ofs_i,
  input wire io_chk_pkg::io_size_t size_i,
  // Verdict
  output logic deny_o
);
  import io_chk_pkg::*;

  logic [15:0] window;

  // A word or dword may spill into the second byte, hence sixteen bits
  assign window = {hi_i, lo_i} >> bit_ofs_i;
  assign deny_o = |(window[3:0] & size_mask(size_i));

endmodule : port_map_window

// file: core/io_port_access_checker.sv
// Port-space access checker with permission map walk and port transfers
//
// Function
// - Port, string port and interrupt-flag ops need privilege at most io field.
// - Flag pop or interrupt return changes io field only at privilege 0.
// - Flag pop changes interrupt flag only when privilege permits; never faults.
// - Protected mode outside vm86 with sufficient privilege allows all port accesses, no map.
// - Lower privilege or vm86 mode consults the permission map.
// - Map byte is port divided by eight, bit is port modulo eight.
// - Every byte port covered is tested; any set bit faults.
// - Two consecutive map bytes are fetched for every checked access.
// - Map bytes past the segment limit count as all set.
// - Map base at or above limit means no map; checked accesses fault.
// - Map located from the task segment's map base field.
// - Register transfers move 8, 16 or 32 bits; port from immediate or index.
// - String transfers use index port and step pointer by direction flag.
// - Port transfers reach only the separate port space.
// - Page cache-disable flag suppresses caching for its page.
// - Io privilege field lives in the task's flags copy.
// - Port space is 64K byte ports, 0 to FFFFH.
`timescale 1ns/1ps
module io_port_access_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Operation requests
  input wire logic req_valid_i,
  input wire io_chk_pkg::io_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic general_protection_fault_o,
  // Permission map fetch
  output io_chk_pkg::map_req_t map_req_o,
  input wire logic map_ack_i,
  input wire logic [7:0] map_data_i,
  // Port space bus and string element side
  output io_chk_pkg::io_bus_t io_bus_o,
  input wire logic io_ack_i,
  input wire logic [31:0] io_rdata_i,
  input wire logic [31:0] str_wdata_i,
  output logic [31:0] str_addr_o,
  output logic [31:0] str_rdata_o,
  // Cacheability
  input wire logic page_cache_disable_i,
  input wire logic cache_enable_pin_n_i,
  output logic cacheable_o
);
  import io_chk_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_MAP_LO, S_MAP_HI, S_CHECK, S_BUS} state_t;

  // ==========================================================
  // State
  state_t state_r, state_nxt;
  io_req_t req_r, req_nxt;
  logic [PORT_W-1:0] port_r, port_nxt;
  logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic [1:0] cpl_r, cpl_nxt, io_privilege_field_r, io_privilege_field_nxt;
  logic prot_r, prot_nxt, vm86_r, vm86_nxt, dir_r, dir_nxt, if_r, if_nxt;
  logic [31:0] tss_base_r, tss_base_nxt, tss_limit_r, tss_limit_nxt;
  logic [15:0] map_base_r, map_base_nxt, port_index_r, port_index_nxt;
  logic [31:0] acc_r, acc_nxt, src_ptr_r, src_ptr_nxt, dst_ptr_r, dst_ptr_nxt;
  logic [31:0] count_r, count_nxt;
  logic last_fault_r, last_fault_nxt;
  logic ready_nxt, done_nxt, gpf_nxt;
  map_req_t map_nxt;
  io_bus_t io_nxt;
  logic [31:0] str_addr_nxt, str_rdata_nxt;
  logic [31:0] wb_dat_nxt;
  logic wb_ack_nxt, cacheable_nxt;

  // ==========================================================
  // Decode helpers
  logic accept, wr_en, deny, sens_deny, need_map, map_absent, route_fault;
  logic is_str_r, hi_sel;
  logic [31:0] rd_word, merged, off_lo, byte_off;
  state_t route_state;

  function automatic logic [31:0] apply_sel(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      apply_sel[8*i +: 8] = sel[i] ? new_w[8*i +: 8] : old_w[8*i +: 8];
    end
  endfunction : apply_sel

  function automatic logic [31:0] merge_acc(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input io_size_t sz);
    unique case (sz)
      SZ_DWORD: merge_acc = new_w;
      SZ_WORD: merge_acc = {old_w[31:16], new_w[15:0]};
      default: merge_acc = {old_w[31:8], new_w[7:0]};
    endcase
  endfunction : merge_acc

  function automatic logic [31:0] step_ptr(input logic [31:0] ptr, input logic down,
                                           input io_size_t sz);
    step_ptr = down ? ptr - size_bytes(sz) : ptr + size_bytes(sz);
  endfunction : step_ptr

  assign accept = req_valid_i & req_ready_o;
  // Writes land on the edge the master samples ack
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign is_str_r = (req_r.op == OP_STR_READ) || (req_r.op == OP_STR_WRITE);
  assign sens_deny = prot_r && (cpl_r > io_privilege_field_r);
  assign need_map = prot_r && ((cpl_r > io_privilege_field_r) || vm86_r);
  assign map_absent = {16'h0000, map_base_r} >= tss_limit_r;
  assign route_fault = need_map && map_absent;
  assign route_state = !need_map ? S_BUS : (map_absent ? S_IDLE : S_MAP_LO);
  // Map offset within the task segment, one bit per port
  assign off_lo = {16'h0000, map_base_r} + {19'h0_0000, port_r[15:3]};
  assign hi_sel = (state_r == S_MAP_HI);
  assign byte_off = off_lo + {31'h0000_0000, hi_sel};

  port_map_window u_window (
    .lo_i(lo_r),
    .hi_i(hi_r),
    .bit_ofs_i(port_r[2:0]),
    .size_i(req_r.size),
    .deny_o(deny)
  );

  // ==========================================================
  // Register read view
  always_comb begin
    rd_word = WORD_RST;
    unique case (wb_adr_i)
      OFS_CTRL: begin
        rd_word[CTRL_CPL_LSB +: 2] = cpl_r;
        rd_word[CTRL_PROT_BIT] = prot_r;
        rd_word[CTRL_VM86_BIT] = vm86_r;
        rd_word[CTRL_DIR_BIT] = dir_r;
      end
      OFS_FLAGS: begin
        rd_word[FLAGS_IF_BIT] = if_r;
        rd_word[FLAGS_IO_PRIVILEGE_FIELD_LSB +: 2] = io_privilege_field_r;
      end
      OFS_TSS_BASE: rd_word = tss_base_r;
      OFS_TSS_LIMIT: rd_word = tss_limit_r;
      OFS_MAP_BASE: rd_word = {16'h0000, map_base_r};
      OFS_PORT_INDEX: rd_word = {16'h0000, port_index_r};
      OFS_ACC: rd_word = acc_r;
      OFS_SRC_PTR: rd_word = src_ptr_r;
      OFS_DST_PTR: rd_word = dst_ptr_r;
      OFS_COUNT: rd_word = count_r;
      OFS_STATUS: begin
        rd_word[STAT_BUSY_BIT] = (state_r != S_IDLE);
        rd_word[STAT_FAULT_BIT] = last_fault_r;
      end
      default: rd_word = WORD_RST;
    endcase
    merged = apply_sel(rd_word, wb_dat_i, wb_sel_i);
    // Unmapped reads answer zero; every access is acknowledged once
    wb_dat_nxt = rd_word;
    wb_ack_nxt = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  // ==========================================================
  // Core next state: software writes first, hardware updates win after
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    port_nxt = port_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    cpl_nxt = cpl_r;
    io_privilege_field_nxt = io_privilege_field_r;
    prot_nxt = prot_r;
    vm86_nxt = vm86_r;
    dir_nxt = dir_r;
    if_nxt = if_r;
    tss_base_nxt = tss_base_r;
    tss_limit_nxt = tss_limit_r;
    map_base_nxt = map_base_r;
    port_index_nxt = port_index_r;
    acc_nxt = acc_r;
    src_ptr_nxt = src_ptr_r;
    dst_ptr_nxt = dst_ptr_r;
    count_nxt = count_r;
    map_nxt = map_req_o;
    io_nxt = io_bus_o;
    str_addr_nxt = str_addr_o;
    str_rdata_nxt = str_rdata_o;
    done_nxt = 1'b0;
    gpf_nxt = 1'b0;
    if (wr_en) begin
      unique case (wb_adr_i)
        OFS_CTRL: begin
          cpl_nxt = merged[CTRL_CPL_LSB +: 2];
          prot_nxt = merged[CTRL_PROT_BIT];
          vm86_nxt = merged[CTRL_VM86_BIT];
          dir_nxt = merged[CTRL_DIR_BIT];
        end
        // A task switch reloads the task's own flags copy here
        OFS_FLAGS: begin
          if_nxt = merged[FLAGS_IF_BIT];
          io_privilege_field_nxt = merged[FLAGS_IO_PRIVILEGE_FIELD_LSB +: 2];
        end
        OFS_TSS_BASE: tss_base_nxt = merged;
        OFS_TSS_LIMIT: tss_limit_nxt = merged;
        OFS_MAP_BASE: map_base_nxt = merged[15:0];
        OFS_PORT_INDEX: port_index_nxt = merged[15:0];
        OFS_ACC: acc_nxt = merged;
        OFS_SRC_PTR: src_ptr_nxt = merged;
        OFS_DST_PTR: dst_ptr_nxt = merged;
        OFS_COUNT: count_nxt = merged;
        default: ;
      endcase
    end
    unique case (state_r)
      S_IDLE: begin
        if (accept) begin
          req_nxt = req_i;
          // Strings always take the index port
          port_nxt = (req_i.use_imm && req_i.op inside {OP_PORT_READ, OP_PORT_WRITE})
                     ? req_i.imm_port : port_index_r;
          unique case (req_i.op)
            OP_FLAG_POP, OP_INT_RETURN: begin
              if (cpl_r == PRIV_KERNEL) io_privilege_field_nxt = req_i.pop_io_privilege_field;
              if (req_i.op == OP_INT_RETURN || !sens_deny) if_nxt = req_i.pop_if;
              done_nxt = 1'b1;
            end
            OP_IF_CLEAR, OP_IF_SET: begin
              if (sens_deny) gpf_nxt = 1'b1;
              else if_nxt = (req_i.op == OP_IF_SET);
              done_nxt = 1'b1;
            end
            default: begin
              // Rep with an empty count only means something for strings
              if (req_i.looping_prefix && count_r == WORD_RST && req_i.op inside {OP_STR_READ, OP_STR_WRITE}) begin
                done_nxt = 1'b1;
              end else begin
                state_nxt = route_state;
                gpf_nxt = route_fault;
                done_nxt = route_fault;
              end
            end
          endcase
        end
      end
      S_MAP_LO, S_MAP_HI: begin
        if (!map_req_o.rd) begin
          if (byte_off > tss_limit_r) begin
            // Past the limit: behave as if every bit were set
            if (hi_sel) hi_nxt = MAP_BYTE_DENY;
            else lo_nxt = MAP_BYTE_DENY;
            state_nxt = hi_sel ? S_CHECK : S_MAP_HI;
          end else begin
            map_nxt.rd = 1'b1;
            map_nxt.addr = tss_base_r + byte_off;
          end
        end else if (map_ack_i) begin
          map_nxt.rd = 1'b0;
          if (hi_sel) hi_nxt = map_data_i;
          else lo_nxt = map_data_i;
          state_nxt = hi_sel ? S_CHECK : S_MAP_HI;
        end
      end
      S_CHECK: begin
        if (deny) begin
          // Fault here keeps the peripheral untouched
          gpf_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = S_IDLE;
        end else begin
          state_nxt = S_BUS;
        end
      end
      S_BUS: begin
        if (!io_bus_o.stb) begin
          io_nxt.stb = 1'b1;
          io_nxt.we = (req_r.op == OP_PORT_WRITE) || (req_r.op == OP_STR_WRITE);
          io_nxt.addr = port_r;
          io_nxt.size = req_r.size;
          io_nxt.wdata = is_str_r ? str_wdata_i : acc_r;
          str_addr_nxt = (req_r.op == OP_STR_READ) ? dst_ptr_r : src_ptr_r;
        end else if (io_ack_i) begin
          io_nxt.stb = 1'b0;
          if (req_r.op == OP_PORT_READ) acc_nxt = merge_acc(acc_r, io_rdata_i, req_r.size);
          if (req_r.op == OP_STR_READ) str_rdata_nxt = io_rdata_i;
          if (req_r.op == OP_STR_READ) dst_ptr_nxt = step_ptr(dst_ptr_r, dir_r, req_r.size);
          if (req_r.op == OP_STR_WRITE) src_ptr_nxt = step_ptr(src_ptr_r, dir_r, req_r.size);
          if (is_str_r && req_r.looping_prefix) count_nxt = count_r - 32'h0000_0001;
          if (is_str_r && req_r.looping_prefix && count_r != 32'h0000_0001) begin
            // Each element is checked again; software may change privilege
            state_nxt = route_state;
            gpf_nxt = route_fault;
            done_nxt = route_fault;
          end else begin
            state_nxt = S_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    ready_nxt = (state_nxt == S_IDLE);
    last_fault_nxt = done_nxt ? gpf_nxt : last_fault_r;
    // Both the pin and the page flag can veto caching
    cacheable_nxt = ~page_cache_disable_i & ~cache_enable_pin_n_i;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      req_r <= '0;
      port_r <= HALF_RST;
      lo_r <= MAP_BYTE_DENY;
      hi_r <= MAP_BYTE_DENY;
      cpl_r <= PRIV_RST;
      io_privilege_field_r <= PRIV_RST;
      prot_r <= 1'b0;
      vm86_r <= 1'b0;
      dir_r <= 1'b0;
      if_r <= 1'b0;
      tss_base_r <= WORD_RST;
      tss_limit_r <= WORD_RST;
      map_base_r <= HALF_RST;
      port_index_r <= HALF_RST;
      acc_r <= WORD_RST;
      src_ptr_r <= WORD_RST;
      dst_ptr_r <= WORD_RST;
      count_r <= WORD_RST;
      last_fault_r <= 1'b0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      general_protection_fault_o <= 1'b0;
      map_req_o <= '0;
      io_bus_o <= '0;
      str_addr_o <= WORD_RST;
      str_rdata_o <= WORD_RST;
      wb_dat_o <= WORD_RST;
      wb_ack_o <= 1'b0;
      cacheable_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      port_r <= port_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      cpl_r <= cpl_nxt;
      io_privilege_field_r <= io_privilege_field_nxt;
      prot_r <= prot_nxt;
      vm86_r <= vm86_nxt;
      dir_r <= dir_nxt;
      if_r <= if_nxt;
      tss_base_r <= tss_base_nxt;
      tss_limit_r <= tss_limit_nxt;
      map_base_r <= map_base_nxt;
      port_index_r <= port_index_nxt;
      acc_r <= acc_nxt;
      src_ptr_r <= src_ptr_nxt;
      dst_ptr_r <= dst_ptr_nxt;
      count_r <= count_nxt;
      last_fault_r <= last_fault_nxt;
      req_ready_o <= ready_nxt;
      done_o <= done_nxt;
      general_protection_fault_o <= gpf_nxt;
      map_req_o <= map_nxt;
      io_bus_o <= io_nxt;
      str_addr_o <= str_addr_nxt;
      str_rdata_o <= str_rdata_nxt;
      wb_dat_o <= wb_dat_nxt;
      wb_ack_o <= wb_ack_nxt;
      cacheable_o <= cacheable_nxt;
    end
  end

  // ==========================================================
  // Assertions and covers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sens_op_fault: assert property (accept && req_i.op inside {OP_IF_CLEAR, OP_IF_SET} && sens_deny
    |=> general_protection_fault_o && done_o && $stable(if_r)) else $error("sensitive op not faulted");
  a_io_privilege_field_hold: assert property (accept && req_i.op inside {OP_FLAG_POP, OP_INT_RETURN} && cpl_r != PRIV_KERNEL
    |=> $stable(io_privilege_field_r) && !general_protection_fault_o) else $error("io field changed off level 0");
  a_io_privilege_field_load: assert property (accept && req_i.op == OP_FLAG_POP && cpl_r == PRIV_KERNEL && !wr_en
    |=> io_privilege_field_r == $past(req_i.pop_io_privilege_field)) else $error("io field not loaded at level 0");
  a_if_pop_guard: assert property (accept && req_i.op == OP_FLAG_POP && sens_deny
    |=> $stable(if_r) && !general_protection_fault_o) else $error("pop changed interrupt flag");
  a_map_bypass: assert property (accept && req_i.op inside {OP_PORT_READ, OP_PORT_WRITE} && !need_map
    |=> state_r == S_BUS ##1 io_bus_o.stb) else $error("map consulted when not needed");
  a_map_consult: assert property (accept && req_i.op inside {OP_PORT_READ, OP_PORT_WRITE} && need_map
    && !map_absent |=> state_r == S_MAP_LO) else $error("map not consulted");
  a_two_bytes: assert property ($rose(state_r == S_CHECK)
    |-> $past(state_r) == S_MAP_HI) else $error("check without second map byte");
  a_beyond_limit: assert property (state_r == S_MAP_LO && !map_req_o.rd && byte_off > tss_limit_r
    |=> lo_r == MAP_BYTE_DENY && !map_req_o.rd) else $error("byte past limit not denied");
  a_map_absent: assert property (accept && req_i.op inside {OP_PORT_READ, OP_PORT_WRITE} && route_fault
    |=> general_protection_fault_o && !io_bus_o.stb) else $error("absent map not faulted");
  a_fault_first: assert property (state_r == S_CHECK && deny
    |=> general_protection_fault_o ##1 !io_bus_o.stb) else $error("bus cycle after denial");
  a_no_cache: assert property (page_cache_disable_i || cache_enable_pin_n_i
    |=> !cacheable_o) else $error("caching not suppressed");
  a_wb_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  c_fault: cover property (state_r == S_CHECK && deny ##1 general_protection_fault_o);
  c_rep_done: cover property (state_r == S_BUS && io_ack_i && is_str_r && req_r.looping_prefix ##1 done_o);
  c_map_pass: cover property (state_r == S_CHECK && !deny ##2 io_bus_o.stb);
  c_pop_kernel: cover property (accept && req_i.op == OP_FLAG_POP && cpl_r == PRIV_KERNEL);

endmodule : io_port_access_checker

// file: tb/io_peer_model.sv
// Model of the permission map memory and a port-space peripheral
`timescale 1ns/1ps
module io_peer_model (
  // Clock, reset and pace
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // Permission map memory
  input wire io_chk_pkg::map_req_t map_req_i,
  output logic map_ack_o,
  output logic [7:0] map_data_o,
  // Port-space peripheral
  input wire io_chk_pkg::io_bus_t io_bus_i,
  output logic io_ack_o,
  output logic [31:0] io_rdata_o,
  output logic [7:0] cycles_o,
  output logic [15:0] last_port_o
);
  // ==========================================================
  // Map image: base 10H, limit 20H
  logic [7:0] map_mem [256];
  int wait_r;
  initial begin
    foreach (map_mem[i]) map_mem[i] = 8'h00;
    map_mem[8'h15] = 8'h02;
    map_mem[8'h16] = 8'h01;
    map_mem[8'h20] = 8'hFF; // All-ones closing byte inside the limit
    map_data_o = 8'h00;
    io_rdata_o = 32'h0000_0000;
  end
  // One-cycle acks; released data lines wander so stale values never match
  always @(posedge clk_i) begin
    map_ack_o <= 1'b0;
    io_ack_o <= 1'b0;
    map_data_o <= ~map_data_o;
    io_rdata_o <= ~io_rdata_o;
    if (rst_i) begin
      wait_r <= 0;
      cycles_o <= 8'h00;
    end else if ((map_req_i.rd || io_bus_i.stb) && !map_ack_o && !io_ack_o) begin
      if (wait_r < (slow_i ? 3 : 0)) wait_r <= wait_r + 1;
      else begin
        wait_r <= 0;
        if (map_req_i.rd) begin
          map_ack_o <= 1'b1;
          map_data_o <= map_mem[map_req_i.addr[7:0]];
        end else begin
          io_ack_o <= 1'b1;
          io_rdata_o <= 32'hA5C3_0F96;
          cycles_o <= cycles_o + 8'h01;
          last_port_o <= io_bus_i.addr;
        end
      end
    end
  end
endmodule : io_peer_model

// file: tb/io_port_access_checker_tb_top.sv
// Testbench of the port access checker: registers, privilege, map walk, strings, caching
`timescale 1ns/1ps
module io_port_access_checker_tb_top;
  import io_chk_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_valid_i, req_ready_o, done_o, slow;
  logic general_protection_fault_o, map_ack_i, io_ack_i, page_cache_disable_i, cache_enable_pin_n_i, cacheable_o;
  logic [7:0] wb_adr_i, map_data_i, ncyc;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, io_rdata_i, q, srd, sadr;
  logic [15:0] lport;
  io_req_t req_i;
  map_req_t map_req_o;
  io_bus_t io_bus_o;
  int fail_count, samples_checked;

  io_port_access_checker io_port_access_checker_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i, .req_i, .req_ready_o, .done_o,
    .general_protection_fault_o, .map_req_o, .map_ack_i, .map_data_i, .io_bus_o, .io_ack_i, .io_rdata_i,
    .str_wdata_i(32'h5A5A_0F0F), .str_addr_o(sadr), .str_rdata_o(srd), .page_cache_disable_i,
    .cache_enable_pin_n_i, .cacheable_o);
  io_peer_model io_peer_model_i (.clk_i, .rst_i, .slow_i(slow), .map_req_i(map_req_o), .map_ack_o(map_ack_i),
    .map_data_o(map_data_i), .io_bus_i(io_bus_o), .io_ack_o(io_ack_i), .io_rdata_o(io_rdata_i),
    .cycles_o(ncyc), .last_port_o(lport));

  // ==========================================================
  // Reporting
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_for(ref logic sig, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sig !== 1'b1 && n < lim);
    if (sig !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      complete_run();
    end
  endtask : wait_for

  // ==========================================================
  // Access tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wait_for(wb_ack_o, 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(q, e);
  endtask : rd_chk
  // Request held until taken, then the fault flag is judged at done
  task automatic op(input io_op_t o, input io_size_t s, input logic [15:0] p, input logic r, input logic e);
    req_i <= '{o, s, 1'b1, p, r, 2'h0, 1'b0};
    req_valid_i <= 1'b1;
    wait_for(req_ready_o, 50);
    req_valid_i <= 1'b0;
    wait_for(done_o, 400);
    check(general_protection_fault_o, e);
  endtask : op
  task automatic cache_chk(input logic d, input logic n, input logic e);
    page_cache_disable_i <= d;
    cache_enable_pin_n_i <= n;
    repeat (3) @(posedge clk_i);
    check(cacheable_o, e);
  endtask : cache_chk

  // ==========================================================
  // Clock and sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cache_enable_pin_n_i, wb_sel_i} = 6'h3F;
    {wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i, page_cache_disable_i, slow} = 6'h00;
    {wb_adr_i, wb_dat_i, req_i} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    rd_chk(8'h3C, 32'h0000_0000);
    $display("test reset done");
    // Privileged enough: no map walk, pop keeps the field at level 3
    wr(OFS_CTRL, 32'h0000_0007);
    wr(OFS_FLAGS, 32'h0000_3200);
    op(OP_PORT_WRITE, SZ_BYTE, 16'h0029, 1'b0, 1'b0);
    check(lport, 16'h0029);
    op(OP_FLAG_POP, SZ_BYTE, 16'h0000, 1'b0, 1'b0);
    rd_chk(OFS_FLAGS, 32'h0000_3000);
    $display("test privilege done");
    // Map walk with a slow map memory
    wr(OFS_FLAGS, 32'h0000_0200);
    wr(OFS_MAP_BASE, 32'h0000_0010);
    wr(OFS_TSS_LIMIT, 32'h0000_0020);
    slow <= 1'b1;
    op(OP_PORT_WRITE, SZ_BYTE, 16'h0029, 1'b0, 1'b1);
    check(ncyc, 8'h01);
    op(OP_PORT_WRITE, SZ_BYTE, 16'h0028, 1'b0, 1'b0);
    op(OP_PORT_READ, SZ_DWORD, 16'h002E, 1'b0, 1'b1);
    op(OP_PORT_READ, SZ_WORD, 16'h002A, 1'b0, 1'b0);
    rd_chk(OFS_ACC, 32'h0000_0F96);
    op(OP_PORT_READ, SZ_BYTE, 16'h0200, 1'b0, 1'b1);
    op(OP_FLAG_POP, SZ_BYTE, 16'h0000, 1'b0, 1'b0);
    rd_chk(OFS_FLAGS, 32'h0000_0200);
    op(OP_IF_CLEAR, SZ_BYTE, 16'h0000, 1'b0, 1'b1);
    wr(OFS_MAP_BASE, 32'h0000_0011);
    op(OP_PORT_WRITE, SZ_BYTE, 16'h0020, 1'b0, 1'b0);
    op(OP_PORT_WRITE, SZ_BYTE, 16'h0021, 1'b0, 1'b1);
    wr(OFS_MAP_BASE, 32'h0000_0020);
    op(OP_PORT_WRITE, SZ_BYTE, 16'h0028, 1'b0, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000_0002);
    $display("test map done");
    // Repeated string reads, up then down
    wr(OFS_FLAGS, 32'h0000_3000);
    wr(OFS_PORT_INDEX, 32'h0000_0060);
    wr(OFS_DST_PTR, 32'h0000_0100);
    wr(OFS_COUNT, 32'h0000_0002);
    op(OP_STR_READ, SZ_BYTE, 16'h0000, 1'b1, 1'b0);
    rd_chk(OFS_DST_PTR, 32'h0000_0102);
    check(lport, 16'h0060);
    check(srd, 32'hA5C3_0F96);
    check(sadr, 32'h0000_0101);
    wr(OFS_CTRL, 32'h0000_0017);
    wr(OFS_COUNT, 32'h0000_0001);
    op(OP_STR_READ, SZ_WORD, 16'h0000, 1'b1, 1'b0);
    rd_chk(OFS_DST_PTR, 32'h0000_0100);
    check(sadr, 32'h0000_0102);
    // Single string write, pointer steps down
    wr(OFS_SRC_PTR, 32'h0000_0200);
    op(OP_STR_WRITE, SZ_BYTE, 16'h0000, 1'b0, 1'b0);
    rd_chk(OFS_SRC_PTR, 32'h0000_01FF);
    check(sadr, 32'h0000_0200);
    op(OP_IF_SET, SZ_BYTE, 16'h0000, 1'b0, 1'b0);
    rd_chk(OFS_FLAGS, 32'h0000_3200);
    // Level 0 in vm86 mode still walks the map, here absent
    wr(OFS_CTRL, 32'h0000_000C);
    op(OP_PORT_READ, SZ_BYTE, 16'h0060, 1'b0, 1'b1);
    op(OP_INT_RETURN, SZ_BYTE, 16'h0000, 1'b0, 1'b0);
    rd_chk(OFS_FLAGS, 32'h0000_0000);
    $display("test string done");
    // Decoder holds the pin high for peripheral ranges
    cache_chk(1'b1, 1'b0, 1'b0);
    cache_chk(1'b0, 1'b1, 1'b0);
    cache_chk(1'b0, 1'b0, 1'b1);
    $display("test cache done");
    complete_run();
  end
endmodule : io_port_access_checker_tb_top
